// ### peripheral_clock_gating.sv
// Wishbone register file and clock enables for the gated peripheral units.
// Assumes one 250 MHz clock, synchronous reset, power state from the same domain.
// How it works
// - Each writable gating bit drives the clock enable of one unit.
// - An access to a unit whose enable is low is answered with a bus fault.
// - All gating bits reset clear except those with a stated other value.
// - Run, sleep and deep-sleep gating registers exist per group with one layout.
// - Sleep and deep-sleep sets act only while auto gating select is set.
// - Group-0 bits 26, 25, 24 gate CAN units two, one, zero, read-write, reset zero.
// - Group-0 bit 3 gates the watchdog, read-write, reset zero.
// - Group-0 deep-sleep register resets to 0x40 with bit 6 read-only one.
// - Group-1 bits 19 to 16 gate timers three to zero, read-write, reset zero.
// - Group-1 bit 12 gates I2C unit zero, read-write, reset zero.
// - Group-1 bits 5 and 4 gate serial units one and zero, read-write, reset zero.
// - Group-1 resets to zero and its reserved ranges read zero.
// - Group-1 bit 0 gates UART unit zero, read-write, reset zero.
`timescale 1ns/1ps
`include "clk_gate_params.svh"
module peripheral_clock_gating
  import clk_gate_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Power state and peripheral access check
  input wire power_state_t pstate_i,
  input wire logic periph_req_i,
  input wire logic [`UNIT_IDX_W-1:0] periph_unit_i,
  output logic periph_ok_o,
  output logic periph_fault_o,
  // Clock enables
  output logic [`UNIT_COUNT-1:0] clk_en_o,
  // Interrupt
  output logic irq_o
);
  gate_cfg_if cfg ();

  logic [31:0] run0;
  logic [31:0] run1;
  logic [31:0] sleep0;
  logic [31:0] sleep1;
  logic [31:0] deep0;
  logic [31:0] deep1;
  logic [31:0] run_clock_config;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [31:0] fault_info;
  logic [31:0] next_dat;
  power_state_t pstate_q;
  bus_state_t bstate;
  logic [31:0] act0;
  logic [31:0] act1;
  logic fault;

  // Gating sets onto the carrier
  assign cfg.run0 = run0;
  assign cfg.run1 = run1;
  assign cfg.sleep0 = sleep0;
  assign cfg.sleep1 = sleep1;
  assign cfg.deep0 = deep0;
  assign cfg.deep1 = deep1;
  assign cfg.auto_gating = run_clock_config[`BIT_AUTO_GATING];

  gate_select u_sel (
    .cfg(cfg),
    .pstate_i(pstate_q),
    .act0_o(act0),
    .act1_o(act1)
  );

  // Per-unit enable map from the active sets, CAN two on top, UART zero in bit 0
  wire [`UNIT_COUNT-1:0] enables = {act0[`BIT_CAN_TWO], act0[`BIT_CAN_ONE],
    act0[`BIT_CAN_ZERO], act0[`BIT_WATCHDOG],
    act1[`BIT_TIMER_THREE:`BIT_TIMER_ZERO], act1[`BIT_I2C_ZERO],
    act1[`BIT_SSI_ONE], act1[`BIT_SSI_ZERO], act1[`BIT_UART_ZERO]};

  fault_check u_fault (
    .unit_i(periph_unit_i),
    .enables_i(enables),
    .fault_o(fault)
  );

  // Byte lane write mask
  wire [31:0] lane = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire bus_req = cyc_i && stb_i && (bstate == BUS_IDLE);
  wire hit_r0 = adr_i == `OFS_RUN_GATE_GROUP0;
  wire hit_r1 = adr_i == `OFS_RUN_GATE_GROUP1;
  wire hit_s0 = adr_i == `OFS_SLEEP_GATE_GROUP0;
  wire hit_s1 = adr_i == `OFS_SLEEP_GATE_GROUP1;
  wire hit_d0 = adr_i == `OFS_DEEPSLEEP_GATE_GROUP0;
  wire hit_d1 = adr_i == `OFS_DEEPSLEEP_GATE_GROUP1;
  wire hit_rcc = adr_i == `OFS_RUN_CLOCK_CONFIG;
  wire hit_ist = adr_i == `OFS_IRQ_STATUS;
  wire hit_imk = adr_i == `OFS_IRQ_MASK;
  wire hit_fi = adr_i == `OFS_FAULT_INFO;
  wire mapped = hit_r0 | hit_r1 | hit_s0 | hit_s1 | hit_d0 | hit_d1 | hit_rcc | hit_ist
    | hit_imk | hit_fi;
  wire wr = bus_req && we_i && mapped;

  // Masked merge: only writable lanes change, reserved bits keep their fixed value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wm);
    merge = (old & ~(wm & lane)) | (dat_i & wm & lane);
  endfunction

  // Events that raise interrupt status
  wire ev_fault = periph_req_i && fault;
  wire ev_mode = pstate_q != pstate_i;
  wire [31:0] ev_set = {30'h0, ev_mode, ev_fault};
  wire [31:0] ist_clr = (wr && hit_ist) ? (dat_i & lane & `IRQ_WMASK) : 32'h0;

  // Read mux; reserved bits come out as stored fixed values
  always_comb
  begin
    next_dat = 32'h0;
    if (hit_r0) next_dat = run0;
    if (hit_r1) next_dat = run1;
    if (hit_s0) next_dat = sleep0;
    if (hit_s1) next_dat = sleep1;
    if (hit_d0) next_dat = deep0;
    if (hit_d1) next_dat = deep1;
    if (hit_rcc) next_dat = run_clock_config;
    if (hit_ist) next_dat = irq_status;
    if (hit_imk) next_dat = irq_mask;
    if (hit_fi) next_dat = fault_info;
  end

  // Gating registers of group 0; three sets share one layout
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run0 <= `GROUP0_RESET;
      sleep0 <= `GROUP0_RESET;
      deep0 <= `GROUP0_RESET;
    end
    else
    begin
      if (wr && hit_r0) run0 <= merge(run0, `GROUP0_WMASK) | `GROUP0_ROMASK;
      if (wr && hit_s0) sleep0 <= merge(sleep0, `GROUP0_WMASK) | `GROUP0_ROMASK;
      if (wr && hit_d0) deep0 <= merge(deep0, `GROUP0_WMASK) | `GROUP0_ROMASK;
    end
  end

  // Gating registers of group 1; reserved bits never written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run1 <= `GROUP1_RESET;
      sleep1 <= `GROUP1_RESET;
      deep1 <= `GROUP1_RESET;
    end
    else
    begin
      if (wr && hit_r1) run1 <= merge(run1, `GROUP1_WMASK);
      if (wr && hit_s1) sleep1 <= merge(sleep1, `GROUP1_WMASK);
      if (wr && hit_d1) deep1 <= merge(deep1, `GROUP1_WMASK);
    end
  end

  // Run clock config and interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_clock_config <= `RCC_RESET;
      irq_mask <= 32'h0;
    end
    else
    begin
      if (wr && hit_rcc) run_clock_config <= merge(run_clock_config, `RCC_WMASK);
      if (wr && hit_imk) irq_mask <= merge(irq_mask, `IRQ_WMASK);
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status <= 32'h0;
    else
      irq_status <= (irq_status & ~ist_clr) | ev_set;
  end

  // Last faulting unit, for software diagnosis
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_info <= 32'h0;
    else if (ev_fault)
      fault_info <= {28'h0, periph_unit_i};
  end

  // Bus handshake: one wait state, ack or err then one idle cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bstate <= BUS_IDLE;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      unique case (bstate)
        BUS_IDLE:
          if (cyc_i && stb_i)
          begin
            bstate <= BUS_ACK;
            ack_o <= mapped;
            err_o <= !mapped;
            dat_o <= (mapped && !we_i) ? next_dat : 32'h0;
          end
        BUS_ACK:
          bstate <= BUS_HOLD;
        BUS_HOLD:
          bstate <= BUS_IDLE;
      endcase
    end
  end

  // Registered outputs: power state, enables, peripheral answer, interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pstate_q <= PWR_RUN;
      clk_en_o <= '0;
      periph_ok_o <= 1'b0;
      periph_fault_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      pstate_q <= pstate_i;
      clk_en_o <= enables;
      periph_ok_o <= periph_req_i && !fault;
      periph_fault_o <= periph_req_i && fault;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Checks
  AST_FAULT_WHEN_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_req_i && fault |=> periph_fault_o && !periph_ok_o)
    else $error("gated access not faulted");
  AST_ENABLE_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> clk_en_o == $past(enables))
    else $error("enable does not follow set");
  AST_RESERVED_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    deep0[6] && run0[6] && sleep0[6])
    else $error("bit 6 not one");
  AST_G1_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    (run1 & ~`GROUP1_WMASK) == 32'h0)
    else $error("group1 reserved bits set");
  AST_NO_AUTO_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_clock_config[`BIT_AUTO_GATING] |-> act0 == run0 && act1 == run1)
    else $error("sleep set used without auto gating");
  AST_DEEP_SELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    run_clock_config[`BIT_AUTO_GATING] && pstate_q == PWR_DEEP |-> act1 == deep1)
    else $error("deep set not selected");
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> clk_en_o == '0 && run1 == 32'h0)
    else $error("enables not clear after reset");
  AST_UART_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_clock_config[`BIT_AUTO_GATING] ##1 1'b1 |-> clk_en_o[0] == $past(run1[`BIT_UART_ZERO]))
    else $error("uart enable mismatch");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  // Bus answers: mapped offsets ack, others err with zero data, never both
  AST_ACK_MAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && mapped |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  AST_ERR_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  AST_ACK_ERR_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o))
    else $error("ack and err together");
  AST_ERR_NO_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o |-> dat_o == 32'h0)
    else $error("refused access returned data");
  // The answer cycle and the idle cycle after it keep a still-held request from being taken twice
  AST_BUSY_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
    bstate != BUS_IDLE |=> !ack_o && !err_o)
    else $error("answer while busy");
  // Layout: only writable fields, plus the fixed one of group 0, may ever be set
  AST_G0_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
    ((run0 | sleep0 | deep0) & ~(`GROUP0_WMASK | `GROUP0_ROMASK)) == 32'h0)
    else $error("group0 reserved bits set");
  AST_G1_SETS_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    ((sleep1 | deep1) & ~`GROUP1_WMASK) == 32'h0)
    else $error("group1 sleep reserved bits set");
  // Set selection by power state
  AST_RUN_SELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    pstate_q == PWR_RUN |-> act0 == run0 && act1 == run1)
    else $error("run set not selected");
  AST_SLEEP_SELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    run_clock_config[`BIT_AUTO_GATING] && pstate_q == PWR_SLEEP |-> act0 == sleep0 && act1 == sleep1)
    else $error("sleep set not selected");
  // Peripheral answers and the status bits they raise
  AST_OK_WHEN_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_req_i && !fault |=> periph_ok_o && !periph_fault_o)
    else $error("clocked unit access refused");
  AST_FAULT_SETS_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_fault |=> irq_status[`IRQ_FAULT_BIT])
    else $error("fault status not set");
  AST_FAULT_INFO: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_fault |=> fault_info[`UNIT_IDX_W-1:0] == $past(periph_unit_i))
    else $error("faulting unit not recorded");
  AST_MODE_SETS_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_mode |=> irq_status[`IRQ_MODE_BIT])
    else $error("mode status not set");
  AST_STATUS_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    ist_clr[`IRQ_FAULT_BIT] && !ev_fault |=> !irq_status[`IRQ_FAULT_BIT])
    else $error("status not cleared by one");
  AST_STATUS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_status[`IRQ_FAULT_BIT] && !ist_clr[`IRQ_FAULT_BIT] |=> irq_status[`IRQ_FAULT_BIT])
    else $error("status bit lost");
  COV_FAULT: cover property (@(posedge clk_i) disable iff (rst_i) periph_fault_o);
  COV_DEEP: cover property (@(posedge clk_i) disable iff (rst_i)
    run_clock_config[`BIT_AUTO_GATING] && pstate_q == PWR_DEEP);
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  COV_SLEEP: cover property (@(posedge clk_i) disable iff (rst_i)
    run_clock_config[`BIT_AUTO_GATING] && pstate_q == PWR_SLEEP);
  COV_ERR: cover property (@(posedge clk_i) disable iff (rst_i) err_o);
endmodule

// ### clk_gate_params.svh
// Register map, field positions, reset values and masks of the peripheral clock gating block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CLK_GATE_PARAMS_SVH
`define CLK_GATE_PARAMS_SVH

`define OFS_RUN_GATE_GROUP0 12'h100
`define OFS_RUN_GATE_GROUP1 12'h104
`define OFS_SLEEP_GATE_GROUP0 12'h110
`define OFS_SLEEP_GATE_GROUP1 12'h114
`define OFS_DEEPSLEEP_GATE_GROUP0 12'h120
`define OFS_DEEPSLEEP_GATE_GROUP1 12'h124
`define OFS_RUN_CLOCK_CONFIG 12'h060
`define OFS_IRQ_STATUS 12'h130
`define OFS_IRQ_MASK 12'h134
`define OFS_FAULT_INFO 12'h138

`define GROUP0_WMASK 32'h07000008
`define GROUP0_ROMASK 32'h00000040
`define GROUP0_RESET 32'h00000040
`define GROUP1_WMASK 32'h000f1031
`define GROUP1_RESET 32'h00000000

`define BIT_CAN_TWO 26
`define BIT_CAN_ONE 25
`define BIT_CAN_ZERO 24
`define BIT_WATCHDOG 3
`define BIT_TIMER_THREE 19
`define BIT_TIMER_ZERO 16
`define BIT_I2C_ZERO 12
`define BIT_SSI_ONE 5
`define BIT_SSI_ZERO 4
`define BIT_UART_ZERO 0

`define BIT_AUTO_GATING 27
`define RCC_WMASK 32'h08000000
`define RCC_RESET 32'h00000000

`define IRQ_WMASK 32'h00000003
`define IRQ_FAULT_BIT 0
`define IRQ_MODE_BIT 1
`define UNIT_COUNT 12
`define UNIT_IDX_W 4

`endif

// ### clk_gate_pkg.sv
// Types shared by the clock gating modules.
// Assumes the constants header is on the include path.
`include "clk_gate_params.svh"
package clk_gate_pkg;
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} power_state_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK, BUS_HOLD} bus_state_t;
endpackage

// ### gate_cfg_if.sv
// Carrier of gating sets between the register file and the gate selector.
// Assumes one clock domain.
`timescale 1ns/1ps
interface gate_cfg_if;
  logic [31:0] run0;
  logic [31:0] run1;
  logic [31:0] sleep0;
  logic [31:0] sleep1;
  logic [31:0] deep0;
  logic [31:0] deep1;
  logic auto_gating;
  modport regs (output run0, run1, sleep0, sleep1, deep0, deep1, auto_gating);
  modport sel (input run0, run1, sleep0, sleep1, deep0, deep1, auto_gating);
endinterface

// ### gate_select.sv
// Picks the active gating set from the power state.
// Assumes power state arrives already synchronous to clk_i.
`timescale 1ns/1ps
module gate_select
  import clk_gate_pkg::*;
(
  // Configuration
  gate_cfg_if.sel cfg,
  input wire power_state_t pstate_i,
  // Selected sets
  output logic [31:0] act0_o,
  output logic [31:0] act1_o
);
  // Sleep sets only count when auto gating is on
  wire use_sleep = cfg.auto_gating && (pstate_i == PWR_SLEEP);
  wire use_deep = cfg.auto_gating && (pstate_i == PWR_DEEP);
  assign act0_o = use_deep ? cfg.deep0 : (use_sleep ? cfg.sleep0 : cfg.run0);
  assign act1_o = use_deep ? cfg.deep1 : (use_sleep ? cfg.sleep1 : cfg.run1);
endmodule

// ### fault_check.sv
// Decides whether a peripheral access must end in a bus fault.
// Assumes the peripheral unit index is valid with the access request.
`timescale 1ns/1ps
`include "clk_gate_params.svh"
module fault_check
(
  // Request
  input wire logic [`UNIT_IDX_W-1:0] unit_i,
  input wire logic [`UNIT_COUNT-1:0] enables_i,
  // Result
  output logic fault_o
);
  // Out-of-range index is treated as a clocked-off unit
  assign fault_o = (unit_i >= `UNIT_IDX_W'(`UNIT_COUNT)) ? 1'b1 : ~enables_i[unit_i];
endmodule

// ### periph_model.sv
// Model of the gated peripheral units, raising access requests.
// Assumes the gating block answers one cycle after a taken request.
`timescale 1ns/1ps
module periph_model
(
  // Clock
  input wire logic clk_i,
  // Access request
  output logic req_o,
  output logic [3:0] unit_o,
  // Answer
  input wire logic ok_i,
  input wire logic fault_i
);
  // Idle request at time zero
  initial
  begin
    req_o = 1'b0;
    unit_o = 4'h0;
  end

  // One access; the answer is sampled at the edge after it is taken
  task automatic touch(input logic [3:0] u, output logic ok, output logic bad);
    @(posedge clk_i);
    req_o <= 1'b1;
    unit_o <= u;
    @(posedge clk_i);
    req_o <= 1'b0;
    unit_o <= ~u; // Released index must not look like the last one
    @(posedge clk_i);
    ok = ok_i;
    bad = fault_i;
  endtask
endmodule

// ### peripheral_clock_gating_bench.sv
// Self-checking bench of the peripheral clock gating block.
// Assumes the register map header and package compiled before it.
`timescale 1ns/1ps
`include "clk_gate_params.svh"
module peripheral_clock_gating_bench
  import clk_gate_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, err_o, req, ok_o, fault_o, irq_o, er, ok, flt;
  logic [3:0] unit;
  logic [11:0] clk_en_o;
  logic [3:0] lanes = 4'hf;
  logic [31:0] rd;
  power_state_t pstate_i = PWR_RUN;
  int bad_count = 0;
  int checks = 0;

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  peripheral_clock_gating uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .pstate_i(pstate_i), .periph_req_i(req), .periph_unit_i(unit),
    .periph_ok_o(ok_o), .periph_fault_o(fault_o), .clk_en_o(clk_en_o), .irq_o(irq_o));

  periph_model model (.clk_i(clk_i), .req_o(req), .unit_o(unit), .ok_i(ok_o),
    .fault_i(fault_o));

  // Value comparison, four-state exact
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Classic cycle; held until the edge that samples ack or err high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= lanes;
    dat_i <= d;
    // No cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask

  task automatic t_reset;
    cmp({20'h0, clk_en_o}, 32'h0);
    rdchk(`OFS_RUN_GATE_GROUP1, 32'h00000000);
    rdchk(`OFS_DEEPSLEEP_GATE_GROUP0, 32'h00000040);
    rdchk(`OFS_RUN_GATE_GROUP0, 32'h00000040);
    wb(1'b0, 12'hffc, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    $display("reset test done");
  endtask

  // One byte lane first, then all ones: only the writable fields may stick
  task automatic t_fields;
    lanes = 4'h4;
    wb(1'b1, `OFS_RUN_GATE_GROUP1, 32'hffffffff);
    lanes = 4'hf;
    rdchk(`OFS_RUN_GATE_GROUP1, 32'h000f0000);
    wb(1'b1, `OFS_RUN_GATE_GROUP1, 32'hffffffff);
    rdchk(`OFS_RUN_GATE_GROUP1, 32'h000f1031);
    wb(1'b1, `OFS_DEEPSLEEP_GATE_GROUP0, 32'h0);
    rdchk(`OFS_DEEPSLEEP_GATE_GROUP0, 32'h00000040);
    wb(1'b1, `OFS_RUN_GATE_GROUP0, 32'hffffffff);
    rdchk(`OFS_RUN_GATE_GROUP0, 32'h07000048);
    cmp({20'h0, clk_en_o}, 32'h00000fff);
    wb(1'b1, `OFS_RUN_GATE_GROUP1, 32'h0);
    cmp({20'h0, clk_en_o}, 32'h00000f00);
    $display("field test done");
  endtask

  // Faulting accesses, masked and unmasked interrupt, clear by one
  task automatic t_access;
    model.touch(4'ha, ok, flt);
    cmp({30'h0, ok, flt}, 32'h2);
    model.touch(4'h0, ok, flt);
    cmp({30'h0, ok, flt}, 32'h1);
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    cmp({31'h0, irq_o}, 32'h0);
    wb(1'b1, `OFS_IRQ_MASK, 32'h1);
    cmp({31'h0, irq_o}, 32'h1);
    model.touch(4'hc, ok, flt);
    cmp({30'h0, ok, flt}, 32'h1);
    rdchk(`OFS_FAULT_INFO, 32'h0000000c);
    wb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    rdchk(`OFS_IRQ_STATUS, 32'h0);
    cmp({31'h0, irq_o}, 32'h0);
    $display("access test done");
  endtask

  // Deep set ignored with auto gating off; deep and sleep sets act with it on
  task automatic t_auto;
    wb(1'b1, `OFS_RUN_GATE_GROUP1, 32'h000f1031);
    pstate_i <= PWR_DEEP;
    repeat (4) @(posedge clk_i);
    cmp({20'h0, clk_en_o}, 32'h00000fff);
    wb(1'b1, `OFS_DEEPSLEEP_GATE_GROUP0, 32'h01000000);
    wb(1'b1, `OFS_RUN_CLOCK_CONFIG, 32'h08000000);
    repeat (4) @(posedge clk_i);
    cmp({20'h0, clk_en_o}, 32'h00000200);
    pstate_i <= PWR_SLEEP;
    repeat (4) @(posedge clk_i);
    cmp({20'h0, clk_en_o}, 32'h0);
    wb(1'b1, `OFS_SLEEP_GATE_GROUP1, 32'hffffffff);
    rdchk(`OFS_SLEEP_GATE_GROUP1, 32'h000f1031);
    cmp({20'h0, clk_en_o}, 32'h000000ff);
    pstate_i <= PWR_RUN;
    repeat (4) @(posedge clk_i);
    cmp({20'h0, clk_en_o}, 32'h00000fff);
    rdchk(`OFS_RUN_GATE_GROUP1, 32'h000f1031);
    wb(1'b1, `OFS_RUN_GATE_GROUP1, rd & ~32'h00000001);
    cmp({20'h0, clk_en_o}, 32'h00000ffe);
    rdchk(`OFS_IRQ_STATUS, 32'h2);
    $display("auto gating test done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_fields;
    t_access;
    t_auto;
    close_out;
  end

  // Hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
